//--- logic/gpo_pkg.sv
// Package for the 8-bit port block: register map, reset values, pin capabilities, sensitivity encodings.
// Assumes a single 10 MHz clock domain and an 8-pin port.
package gpo_pkg;
  localparam int unsigned GPO_WIDTH = 8;  // Pins per port
  localparam int unsigned GPO_AW = 4;  // Register address width
  // Register offsets
  localparam logic [3:0] GPO_OFS_DATA = 4'h0;  // pin_data_latch
  localparam logic [3:0] GPO_OFS_DIR = 4'h1;  // Direction
  localparam logic [3:0] GPO_OFS_OPT = 4'h2;  // Option
  localparam logic [3:0] GPO_OFS_SENS = 4'h3;  // ext_irq_sensitivity
  localparam logic [3:0] GPO_OFS_STAT = 4'h4;  // Sticky event status
  localparam logic [3:0] GPO_OFS_MASK = 4'h5;  // Interrupt mask
  localparam logic [3:0] GPO_OFS_IRQCAP = 4'h6;  // Pins able to interrupt
  localparam logic [3:0] GPO_OFS_PULLCAP = 4'h7;  // Pins with a pull-up
  // Reset values
  localparam logic [7:0] GPO_RST_REG = 8'h00;
  localparam logic [1:0] GPO_RST_SENS = 2'h0;
  // Default per-pin capabilities (plain defaults)
  localparam logic [7:0] GPO_IRQ_PINS = 8'h0f;
  localparam logic [7:0] GPO_PULL_PINS = 8'hff;
  // Sensitivity encodings
  typedef enum logic [1:0] {
    GPO_SENS_FALL_LOW,
    GPO_SENS_RISE,
    GPO_SENS_FALL,
    GPO_SENS_BOTH
  } gpo_sens_e;
endpackage

//--- logic/gpo_port.sv
// Eight-pin general-purpose port with alternate-function override,
// open-drain/push-pull selection, pull-up control and external interrupt.
// Assumes pad inputs are asynchronous and pass two flip-flops first;
// the register port, peripheral signals and sleep flags are on i_mclk.
`timescale 1ns/10ps
`default_nettype none

module gpo_port (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [gpo_pkg::GPO_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_pad,
  output logic [7:0] o_pad,
  output logic [7:0] o_pad_oe,
  output logic [7:0] o_pull_en,
  input wire logic [7:0] i_alt_en,
  input wire logic [7:0] i_alt_out_en,
  input wire logic [7:0] i_alt_out,
  input wire logic [7:0] i_alt_od,
  output logic [7:0] o_alt_in,
  input wire logic i_cc_mask,
  input wire logic i_sleep,
  output logic o_ext_req,
  output logic o_wake,
  output logic o_irq
);
  import gpo_pkg::*;

  // Software registers
  logic [7:0] latch_q;  // pin_data_latch
  logic [7:0] dir_q;  // One selects output
  logic [7:0] opt_q;  // Drive style or input flavour
  logic [1:0] sens_q;  // ext_irq_sensitivity
  logic [7:0] stat_q;  // Sticky pin events, write one to clear
  logic [7:0] mask_q;  // Events allowed onto o_irq
  // Pad synchroniser: stage one is read only by stage two
  logic [7:0] pad_s1_q;
  logic [7:0] pad_s2_q;
  logic [7:0] pad_prev_q;  // For edge detection
  logic [7:0] rdata_q;
  logic [7:0] pad_q;
  logic [7:0] oe_q;
  logic [7:0] pull_q;
  logic [7:0] alt_in_q;
  logic req_q;
  logic wake_q;
  logic irq_q;

  // Decodes an offset hit from an address
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // Write strobes, one per writable register
  // Offsets 6 and 7 have no strobe, so they stay read-only
  wire logic wr_data = i_wr && hit(i_addr, GPO_OFS_DATA);
  wire logic wr_dir = i_wr && hit(i_addr, GPO_OFS_DIR);
  wire logic wr_opt = i_wr && hit(i_addr, GPO_OFS_OPT);
  wire logic wr_sens = i_wr && hit(i_addr, GPO_OFS_SENS);
  wire logic wr_stat = i_wr && hit(i_addr, GPO_OFS_STAT);
  wire logic wr_mask = i_wr && hit(i_addr, GPO_OFS_MASK);

  // Per-pin decoded drive, pull and peripheral feed
  logic [7:0] drv_en;
  logic [7:0] drv_val;
  logic [7:0] pull_d;
  logic [7:0] alt_in_d;
  logic [7:0] irq_mode;
  logic [7:0] det;
  logic [7:0] data_view;

  genvar n;
  generate
    for (n = 0; n < GPO_WIDTH; n++) begin : g_pin
      // Drive source: peripheral wins over ordinary settings
      wire logic out_mode = i_alt_out_en[n] | dir_q[n];
      wire logic val = i_alt_out_en[n] ? i_alt_out[n] : latch_q[n];
      wire logic od = i_alt_out_en[n] ? i_alt_od[n] : ~opt_q[n];
      // Open drain only drives a zero; a one floats
      assign drv_en[n] = out_mode & (~od | ~val);
      assign drv_val[n] = val;
      // Pull-up needs input, option set, pad with pull, no driver
      assign pull_d[n] = ~out_mode & opt_q[n] & GPO_PULL_PINS[n];
      // Output pin feeds its latch to the peripheral input
      assign alt_in_d[n] = dir_q[n] ? latch_q[n] : pad_s2_q[n];
      // Input with interrupt selected by dir 0, option 1 on capable pins
      assign irq_mode[n] = ~dir_q[n] & opt_q[n] & GPO_IRQ_PINS[n];
      // Output reads latch, input reads the pin
      assign data_view[n] = dir_q[n] ? latch_q[n] : pad_s2_q[n];
    end
  endgenerate

  // Edge or level detection per sensitivity
  // Detection runs on the synchronised level, so a glitch shorter
  // than a clock may be missed; that is the price of a clean sample
  always_comb begin
    unique case (gpo_sens_e'(sens_q))
      GPO_SENS_FALL_LOW: det = ~pad_s2_q;
      GPO_SENS_RISE: det = pad_s2_q & ~pad_prev_q;
      GPO_SENS_FALL: det = ~pad_s2_q & pad_prev_q;
      GPO_SENS_BOTH: det = pad_s2_q ^ pad_prev_q;
    endcase
  end

  wire logic [7:0] ev = det & irq_mode;  // Detected, enabled pin events
  wire logic any_ev = |ev;
  // Mask in the condition code gates the request
  wire logic req_d = any_ev & ~i_cc_mask;
  // Sleep changes nothing on the port; an event wakes
  wire logic wake_d = i_sleep & any_ev;
  // Sticky status: a new event wins over a write-one clear
  wire logic [7:0] stat_d = (stat_q & ~(wr_stat ? i_wdata : 8'h00)) | ev;

  // Read mux; unmapped addresses read zero
  // Later tests win, but the offsets never overlap
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit(i_addr, GPO_OFS_DATA)) rd_mux = data_view;
    if (hit(i_addr, GPO_OFS_DIR)) rd_mux = dir_q;
    if (hit(i_addr, GPO_OFS_OPT)) rd_mux = opt_q;
    if (hit(i_addr, GPO_OFS_SENS)) rd_mux = {6'h00, sens_q};
    if (hit(i_addr, GPO_OFS_STAT)) rd_mux = stat_q;
    if (hit(i_addr, GPO_OFS_MASK)) rd_mux = mask_q;
    if (hit(i_addr, GPO_OFS_IRQCAP)) rd_mux = GPO_IRQ_PINS;
    if (hit(i_addr, GPO_OFS_PULLCAP)) rd_mux = GPO_PULL_PINS;
  end

  // Software registers; data write only updates the latch
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      latch_q <= GPO_RST_REG;
      dir_q <= GPO_RST_REG;
      opt_q <= GPO_RST_REG;
      sens_q <= GPO_RST_SENS;
      mask_q <= GPO_RST_REG;
      stat_q <= GPO_RST_REG;
    end else begin
      if (wr_data) latch_q <= i_wdata;
      if (wr_dir) dir_q <= i_wdata;
      if (wr_opt) opt_q <= i_wdata;
      if (wr_sens) sens_q <= i_wdata[1:0];
      if (wr_mask) mask_q <= i_wdata;
      stat_q <= stat_d;
    end
  end

  // Pad synchroniser and edge history
  // Stage one may go metastable; only stage two feeds any logic
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pad_s1_q <= GPO_RST_REG;
      pad_s2_q <= GPO_RST_REG;
      pad_prev_q <= GPO_RST_REG;
    end else begin
      pad_s1_q <= i_pad;
      pad_s2_q <= pad_s1_q;
      pad_prev_q <= pad_s2_q;
    end
  end

  // Registered outputs; pad path adds a cycle to keep outputs glitch free
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= GPO_RST_REG;
      pad_q <= GPO_RST_REG;
      oe_q <= GPO_RST_REG;
      pull_q <= GPO_RST_REG;
      alt_in_q <= GPO_RST_REG;
      req_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= i_rd ? rd_mux : 8'h00;
      pad_q <= drv_val;
      oe_q <= drv_en;
      pull_q <= pull_d;
      alt_in_q <= alt_in_d;
      req_q <= req_d;
      wake_q <= wake_d;
      irq_q <= |(stat_d & mask_q);
    end
  end

  // Outputs come straight from their flip-flops
  assign o_rdata = rdata_q;
  assign o_pad = pad_q;
  assign o_pad_oe = oe_q;
  assign o_pull_en = pull_q;
  assign o_alt_in = alt_in_q;
  assign o_ext_req = req_q;
  assign o_wake = wake_q;
  assign o_irq = irq_q;

  // Peripheral input enable is only a qualifier for the sink
  wire logic unused_alt = |i_alt_en;

  // Assertions
  a_out_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (dir_q[0] && !i_alt_out_en[0] && opt_q[0]) |=> (o_pad_oe[0] && o_pad[0] == $past(latch_q[0])))
    else $error("Push-pull output not driving latch");
  a_od_float: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (dir_q[1] && !i_alt_out_en[1] && !opt_q[1] && latch_q[1]) |=> !o_pad_oe[1])
    else $error("Open-drain one was driven");
  a_low_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (dir_q[2] && !i_alt_out_en[2] && !latch_q[2]) |=> (o_pad_oe[2] && !o_pad[2]))
    else $error("Zero not driven low");
  a_read_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_rd && i_addr == GPO_OFS_DATA && dir_q == 8'hff) |=> (o_rdata == $past(latch_q)))
    else $error("Output read not latch");
  a_read_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_rd && i_addr == GPO_OFS_DATA && dir_q == 8'h00) |=> (o_rdata == $past(pad_s2_q)))
    else $error("Input read not pin");
  a_alt_force: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_alt_out_en[3] && !i_alt_od[3]) |=> (o_pad_oe[3] && o_pad[3] == $past(i_alt_out[3])))
    else $error("Peripheral drive not forced");
  a_alt_feed: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    dir_q[4] |=> (o_alt_in[4] == $past(latch_q[4])))
    else $error("Peripheral input not fed latch");
  a_irq_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_cc_mask || irq_mode == 8'h00) |=> !o_ext_req)
    else $error("Request while masked or disabled");
  a_pull_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (dir_q[5] || i_alt_out_en[5]) |=> !o_pull_en[5])
    else $error("Pull-up on driven pin");
  a_in_nodrive: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!dir_q[6] && !i_alt_out_en[6]) |=> !o_pad_oe[6])
    else $error("Input pin driven");

  // Peripheral open-drain one floats
  a_alt_odfloat: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_alt_out_en[7] && i_alt_od[7] && i_alt_out[7]) |=> !o_pad_oe[7])
    else $error("Peripheral open-drain one driven");
  // Pull-up present on an undriven input with option set
  a_pull_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!dir_q[5] && !i_alt_out_en[5] && opt_q[5]) |=> o_pull_en[5])
    else $error("Pull-up missing on input");
  // Data read returns the per-pin view
  a_read_view: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_rd && i_addr == GPO_OFS_DATA) |=> (o_rdata == $past(data_view)))
    else $error("Data read not pin view");

  // Interrupt, request and wake-up paths
  a_req_event: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!i_cc_mask && any_ev) |=> o_ext_req)
    else $error("Unmasked event gave no request");
  a_wake_event: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_sleep && any_ev) |=> o_wake)
    else $error("Event in sleep gave no wake");
  a_wake_awake: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_sleep |=> !o_wake)
    else $error("Wake while not sleeping");
  a_stat_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (stat_q[0] && !(wr_stat && i_wdata[0])) |=> stat_q[0])
    else $error("Status bit lost without clear");
  a_stat_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ev[0] |=> stat_q[0])
    else $error("Event did not set status");
  a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (|(stat_d & mask_q)) |=> o_irq)
    else $error("Unmasked status without interrupt");

  // Main scenarios worth seeing at least once
  c_alt_out: cover property (@(posedge i_mclk) disable iff (!i_rst_b) i_alt_out_en[0] && o_pad_oe[0]);
  c_ext_req: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_ext_req);
  c_wake: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_wake);
  c_irq: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_irq);
  c_stat_clr: cover property (@(posedge i_mclk) disable iff (!i_rst_b) wr_stat && stat_q != 8'h00);
endmodule

`default_nettype wire

//--- verif/gpo_pad_model.sv
// Pad model for the port: resolves each pin from the port's drive,
// its pull-up and an outside driver. Assumes a single clock, i_mclk.
`timescale 1ns/10ps
`default_nettype none
module gpo_pad_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pull,
  input wire logic [7:0] i_ext,
  input wire logic [7:0] i_ext_drv,
  output logic [7:0] o_lvl
);
  logic [7:0] last_q = 8'h00; // Last level, so a floating pin never holds steady
  // Port drive wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_oe[i]) o_lvl[i] = i_out[i];
      else if (i_ext_drv[i]) o_lvl[i] = i_ext[i];
      else if (i_pull[i]) o_lvl[i] = 1'b1;
      else o_lvl[i] = ~last_q[i]; // Floating: flips each cycle
    end
  end
  always @(posedge i_mclk) last_q <= o_lvl;
endmodule
`default_nettype wire

//--- verif/gpo_port_tb.sv
// Self-checking bench for the port: register tasks, pad and peripheral
// stimulus. Assumes the pad model beside the design and one 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module gpo_port_tb;
  import gpo_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0, i_rd = 1'b0, cc = 1'b1, slp = 1'b0, seen = 1'b0;
  logic [7:0] aoe = 8'h00, ao = 8'h00, aod = 8'h00, ext = 8'h00, drv = 8'h00;
  logic [7:0] rdata, pad, oe, pull, lvl, alt_in;
  logic req, wake, irq;
  int miscompares = 0, checked = 0;
  initial forever #50 i_mclk = ~i_mclk;
  gpo_port dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_pad(lvl), .o_pad(pad), .o_pad_oe(oe),
    .o_pull_en(pull), .i_alt_en(8'hff), .i_alt_out_en(aoe), .i_alt_out(ao), .i_alt_od(aod),
    .o_alt_in(alt_in), .i_cc_mask(cc), .i_sleep(slp), .o_ext_req(req), .o_wake(wake), .o_irq(irq));
  gpo_pad_model pads (.i_mclk(i_mclk), .i_out(pad), .i_oe(oe), .i_pull(pull), .i_ext(ext),
    .i_ext_drv(drv), .o_lvl(lvl));
  // Catches one-cycle requests from edge detection
  always @(posedge i_mclk) if (req) seen <= 1'b1;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Waits n edges, then steps off the edge to sample
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    cyc(2);
    rd("dir", GPO_OFS_DIR, GPO_RST_REG);
    wr(GPO_OFS_IRQCAP, 8'hff);
    rd("irqcap", GPO_OFS_IRQCAP, GPO_IRQ_PINS);
    rd("pullcap", GPO_OFS_PULLCAP, GPO_PULL_PINS);
    wr(4'h9, 8'h55);
    rd("unmapped", 4'h9, 8'h00);
    // Latch first, then direction, so pins start at the right level
    wr(GPO_OFS_DATA, 8'ha5);
    wr(GPO_OFS_OPT, 8'h0f);
    wr(GPO_OFS_DIR, 8'hff);
    drv <= 8'hff;
    cyc(3);
    chk("oe", oe, 8'h5f);
    chk("pad", pad & oe, 8'h05);
    chk("alt_in", alt_in, 8'ha5);
    rd("latch", GPO_OFS_DATA, 8'ha5);
    // Input: pull-ups on the high nibble, low nibble driven outside
    wr(GPO_OFS_DIR, 8'h00);
    wr(GPO_OFS_OPT, 8'hf0);
    wr(GPO_OFS_DATA, 8'h3c);
    drv <= 8'h0f;
    ext <= 8'h06;
    cyc(5);
    chk("pull", pull, 8'hf0);
    chk("oe_in", oe, 8'h00);
    chk("alt_in2", alt_in, 8'hf6);
    rd("pin", GPO_OFS_DATA, 8'hf6);
    // Peripheral drives pins 0 and 3 push-pull high and pin 7 open-drain low
    @(posedge i_mclk);
    aoe <= 8'h89;
    ao <= 8'h09;
    aod <= 8'h80;
    cyc(3);
    chk("alt_oe", oe, 8'h89);
    chk("alt_pad", pad & oe, 8'h09);
    chk("alt_pull", pull, 8'h70);
    // Pin 0 as low-level interrupt input, CPU mask still set
    @(posedge i_mclk);
    aoe <= 8'h00;
    ext <= 8'h00;
    wr(GPO_OFS_SENS, {6'h00, GPO_SENS_FALL_LOW});
    wr(GPO_OFS_MASK, 8'h01);
    wr(GPO_OFS_OPT, 8'h01);
    cyc(4);
    chk("req_cc", 8'(req), 8'h00);
    chk("irq", 8'(irq), 8'h01);
    @(posedge i_mclk);
    cc <= 1'b0;
    slp <= 1'b1;
    cyc(3);
    chk("req", 8'(req), 8'h01);
    chk("wake", 8'(wake), 8'h01);
    chk("pull_slp", pull, 8'h01);
    @(posedge i_mclk);
    slp <= 1'b0;
    wr(GPO_OFS_OPT, 8'h00);
    wr(GPO_OFS_STAT, 8'hff);
    cyc(3);
    chk("req_off", 8'(req), 8'h00);
    chk("irq_clr", 8'(irq), 8'h00);
    // Masked pin 1: status sets, interrupt line stays low
    wr(GPO_OFS_MASK, 8'h00);
    wr(GPO_OFS_OPT, 8'h02);
    cyc(3);
    chk("irq_msk", 8'(irq), 8'h00);
    rd("stat", GPO_OFS_STAT, 8'h02);
    // Each edge sensitivity on pin 1
    for (int s = 1; s < 4; s++) begin
      wr(GPO_OFS_SENS, 8'(s));
      cyc(4);
      seen = 1'b0;
      @(posedge i_mclk);
      ext <= 8'h02;
      cyc(4);
      chk("rise", 8'(seen), 8'(s != 2));
      seen = 1'b0;
      @(posedge i_mclk);
      ext <= 8'h00;
      cyc(4);
      chk("fall", 8'(seen), 8'(s != 1));
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
